/* core/scfg_pkg.sv */
/*
 * Package for the system configuration and strap-mode block: register
 * offsets, field positions, reset values, mode encoding and carrier structs.
 * Assumes a 32-bit APB bus and a single 125 MHz clock domain.
 */
package scfg_pkg;

  // ************************************************************
  // register map (byte addresses, one aligned word each)
  // ************************************************************
  localparam logic [11:0] MODULE_CONFIGURATION_OFFSET = 12'h000;
  localparam logic [11:0] MODULE_STATUS_OFFSET        = 12'h004;
  localparam logic [11:0] EVENT_STATUS_OFFSET         = 12'h008;
  localparam logic [11:0] EVENT_MASK_OFFSET           = 12'h00C;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CPU_CLOCK_OUT_ENABLE_BIT   = 1;
  localparam int GEN_CLOCK_A_OUT_ENABLE_BIT = 2;
  localparam int GEN_CLOCK_B_OUT_ENABLE_BIT = 5;
  localparam int STRAP_LOW_BIT              = 0;
  localparam int STRAP_HIGH_BIT             = 1;
  localparam int FLASH_PROGRAM_BUSY_BIT     = 3;
  localparam int EVT_BUSY_RISE_BIT          = 0;
  localparam int EVT_BUSY_FALL_BIT          = 1;

  // writable bits of module_configuration; reserved bits stay zero
  localparam logic [7:0] MODULE_CONFIGURATION_WMASK = 8'h26;
  localparam logic [7:0] MODULE_CONFIGURATION_RESET = 8'h00;
  localparam logic [1:0] EVENT_RESET                = 2'h0;

  // ************************************************************
  // timing
  // ************************************************************
  // length of the boot-branch substitution window in cycles
  localparam logic [3:0] BOOT_SUBST_CYCLES = 4'h4;
  // edges after reset release before the strap latch; covers both sync flops
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

  // ************************************************************
  // operating environments
  // ************************************************************
  typedef enum logic [1:0] {
    SCFG_ENV_FLASH_TEST = 2'h0,
    SCFG_ENV_TEST       = 2'h1,
    SCFG_ENV_ISP        = 2'h2,
    SCFG_ENV_NORMAL     = 2'h3
  } scfg_env_t;

  // boot sequencer, Gray coded along the substitution path
  typedef enum logic [1:0] {
    SCFG_BOOT_IDLE  = 2'b00,
    SCFG_BOOT_SUBST = 2'b01,
    SCFG_BOOT_DONE  = 2'b11
  } scfg_boot_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } scfg_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } scfg_apb_rsp_t;

  typedef struct packed {
    logic cpuClockOe;
    logic genClockAOe;
    logic genClockBOe;
    logic cpuClockOut;
    logic genClockAPin;
    logic genClockBPin;
  } scfg_clk_pins_t;

endpackage : scfg_pkg

/* core/scfg_strap_mode.sv */
/*
 * System configuration block: samples the two environment straps after
 * reset release, picks the operating environment, runs the boot-branch substitution
 * for programming mode, and holds the configuration and status registers.
 * Assumes straps are pins (synchronised here), the flash busy and empty
 * flags come from flash logic on clk, and the prescaled clocks arrive on clk.
 */
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

// Operation
// - strap pair selects one of four environments
// - mode fixed at reset until next reset
// - both high and empty memory gives programming
// - strap pull-ups enabled during reset sampling
// - programming mode substitutes boot branch first fetch
// - configuration register clears to zero on reset
// - configuration kept across all power modes
// - cpu clock pin driven only when enabled
// - generated clock a driven when enabled
// - clock b needs enable and cpu clock off
// - status bits hold captured strap levels
// - status bit three shows flash programming busy
module scfg_strap_mode (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // apb slave
  input  wire scfg_pkg::scfg_apb_req_t apbReq,
  output      scfg_pkg::scfg_apb_rsp_t apbRsp,
  // strap pins
  input  wire logic                    strapSelLowN,
  input  wire logic                    strapSelHighN,
  output      logic                    strapPullUpEnable,
  // flash status
  input  wire logic                    programMemoryEmptyFlag,
  input  wire logic                    programFlashBusy,
  input  wire logic                    dataFlashBusy,
  // clock sources
  input  wire logic                    cpuClock,
  input  wire logic                    slowPrescalerDividerA,
  input  wire logic                    slowPrescalerDividerB,
  // mode and boot
  output      scfg_pkg::scfg_env_t     operatingMode,
  output      logic                    inSystemProgrammingMode,
  output      logic                    flashFetchDisable,
  output      logic                    bootBranchSubstitute,
  // clock pins
  output      scfg_pkg::scfg_clk_pins_t clkPins,
  // interrupt
  output      logic                    irq
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic                 sampled;
    logic [1:0]           settle;
    logic [1:0]           strapBits;
    scfg_pkg::scfg_env_t  mode;
    scfg_pkg::scfg_boot_t boot;
    logic [3:0]           bootCount;
    logic [7:0]           cfgReg;
    logic                 busy;
    logic [1:0]           evtStatus;
    logic [1:0]           evtMask;
    logic                 ack;
    logic [31:0]          rdata;
    logic                 slvErr;
  } scfg_state_t;

  scfg_state_t st;
  scfg_state_t next_st;

  logic        strapLowSync;
  logic        strapHighSync;
  logic        access;
  logic        capture;
  logic        complete;
  logic        doWrite;
  logic        doRead;
  logic        busyNow;
  logic [1:0]  evtSet;
  logic        hit;
  logic [31:0] readVal;

  // ************************************************************
  // strap synchronisers
  // ************************************************************
  scfg_sync2 syncLow (
    .clk  (clk),
    .rst  (rst),
    .din  (strapSelLowN),
    .dout (strapLowSync)
  );

  scfg_sync2 syncHigh (
    .clk  (clk),
    .rst  (rst),
    .din  (strapSelHighN),
    .dout (strapHighSync)
  );

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    access   = apbReq.psel && apbReq.penable;
    // one wait state: the first access cycle captures read data into a
    // flop, the second raises pready; writes land only on that second edge
    capture  = access && !st.ack;
    complete = access && st.ack;
    doWrite  = complete && apbReq.pwrite;
    // read side effects happen at capture so no event slips in between
    doRead   = capture && !apbReq.pwrite;
    busyNow = programFlashBusy || dataFlashBusy;
    evtSet  = 2'h0;
    evtSet[scfg_pkg::EVT_BUSY_RISE_BIT] = busyNow && !st.busy;
    evtSet[scfg_pkg::EVT_BUSY_FALL_BIT] = !busyNow && st.busy;
    hit     = 1'b1;
    readVal = 32'h0000_0000;
    case (apbReq.paddr)
      scfg_pkg::MODULE_CONFIGURATION_OFFSET: readVal[7:0] = st.cfgReg;
      scfg_pkg::MODULE_STATUS_OFFSET: begin
        // reserved positions stay zero
        readVal[scfg_pkg::STRAP_LOW_BIT]          = st.strapBits[0];
        readVal[scfg_pkg::STRAP_HIGH_BIT]         = st.strapBits[1];
        readVal[scfg_pkg::FLASH_PROGRAM_BUSY_BIT] = st.busy;
      end
      scfg_pkg::EVENT_STATUS_OFFSET: readVal[1:0] = st.evtStatus;
      scfg_pkg::EVENT_MASK_OFFSET:   readVal[1:0] = st.evtMask;
      default: hit = 1'b0;
    endcase

    next_st = st;
    next_st.busy  = busyNow;

    // the sync flops hold their reset level, so wait until both carry pin
    // levels; latch once, then freeze until the next reset
    if (!st.sampled) begin
      if (st.settle == scfg_pkg::STRAP_SETTLE_CYCLES) begin
        next_st.sampled   = 1'b1;
        next_st.strapBits = {strapHighSync, strapLowSync};
        case ({strapHighSync, strapLowSync})
          2'b00:   next_st.mode = scfg_pkg::SCFG_ENV_FLASH_TEST;
          2'b01:   next_st.mode = scfg_pkg::SCFG_ENV_TEST;
          2'b10:   next_st.mode = scfg_pkg::SCFG_ENV_ISP;
          default: next_st.mode = programMemoryEmptyFlag ? scfg_pkg::SCFG_ENV_ISP
                                                        : scfg_pkg::SCFG_ENV_NORMAL;
        endcase
      end else begin
        next_st.settle = st.settle + 2'h1;
      end
    end

    // boot branch substitution while flash fetch is held off
    case (st.boot)
      scfg_pkg::SCFG_BOOT_IDLE: begin
        if (st.sampled) begin
          if (st.mode == scfg_pkg::SCFG_ENV_ISP) begin
            next_st.boot      = scfg_pkg::SCFG_BOOT_SUBST;
            next_st.bootCount = scfg_pkg::BOOT_SUBST_CYCLES;
          end else begin
            next_st.boot = scfg_pkg::SCFG_BOOT_DONE;
          end
        end
      end
      scfg_pkg::SCFG_BOOT_SUBST: begin
        next_st.bootCount = st.bootCount - 4'h1;
        if (st.bootCount == 4'h1) begin
          next_st.boot = scfg_pkg::SCFG_BOOT_DONE;
        end
      end
      scfg_pkg::SCFG_BOOT_DONE: next_st.boot = scfg_pkg::SCFG_BOOT_DONE;
      default:                  next_st.boot = scfg_pkg::SCFG_BOOT_IDLE;
    endcase

    // no power-mode input touches config, so it is kept
    if (doWrite) begin
      case (apbReq.paddr)
        scfg_pkg::MODULE_CONFIGURATION_OFFSET:
          next_st.cfgReg = apbReq.pwdata[7:0] & scfg_pkg::MODULE_CONFIGURATION_WMASK;
        scfg_pkg::EVENT_MASK_OFFSET: next_st.evtMask = apbReq.pwdata[1:0];
        default: ; // status is read only
      endcase
    end

    // read clears, but a new event in the same cycle wins
    if (doRead && apbReq.paddr == scfg_pkg::EVENT_STATUS_OFFSET) begin
      next_st.evtStatus = evtSet;
    end else begin
      next_st.evtStatus = st.evtStatus | evtSet;
    end

    // read data and error stand in flops until the next capture
    next_st.ack = capture;
    if (capture) begin
      next_st.rdata  = apbReq.pwrite ? 32'h0000_0000 : readVal;
      next_st.slvErr = !hit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st           <= '0;
      st.strapBits <= 2'h3;
      st.mode      <= scfg_pkg::SCFG_ENV_NORMAL;
      st.boot      <= scfg_pkg::SCFG_BOOT_IDLE;
      st.cfgReg    <= scfg_pkg::MODULE_CONFIGURATION_RESET;
      st.evtStatus <= scfg_pkg::EVENT_RESET;
      st.evtMask   <= scfg_pkg::EVENT_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  logic cpuOe;
  logic genAOe;
  logic genBOe;

  always_comb begin
    // pready follows the capture flop, so prdata is a registered value
    apbRsp.pready  = st.ack;
    apbRsp.prdata  = st.rdata;
    apbRsp.pslverr = st.ack && st.slvErr;
    // pull-ups stay on until the straps are latched
    strapPullUpEnable       = rst || !st.sampled;
    operatingMode           = st.mode;
    inSystemProgrammingMode = st.mode == scfg_pkg::SCFG_ENV_ISP;
    flashFetchDisable       = st.boot == scfg_pkg::SCFG_BOOT_SUBST;
    bootBranchSubstitute    = st.boot == scfg_pkg::SCFG_BOOT_SUBST;
    cpuOe  = st.cfgReg[scfg_pkg::CPU_CLOCK_OUT_ENABLE_BIT]
             && st.mode == scfg_pkg::SCFG_ENV_NORMAL;
    genAOe = st.cfgReg[scfg_pkg::GEN_CLOCK_A_OUT_ENABLE_BIT];
    genBOe = st.cfgReg[scfg_pkg::GEN_CLOCK_B_OUT_ENABLE_BIT]
             && !st.cfgReg[scfg_pkg::CPU_CLOCK_OUT_ENABLE_BIT];
    clkPins.cpuClockOe   = cpuOe;
    clkPins.genClockAOe  = genAOe;
    clkPins.genClockBOe  = genBOe;
    clkPins.cpuClockOut  = cpuOe  && cpuClock;
    clkPins.genClockAPin = genAOe && slowPrescalerDividerA;
    clkPins.genClockBPin = genBOe && slowPrescalerDividerB;
    irq = |(st.evtStatus & st.evtMask);
  end

  // ************************************************************
  // elaboration checks
  // ************************************************************
  // a zero count would wrap the substitution counter; fewer than two
  // settle edges would latch the straps before the second flop fills
  if (scfg_pkg::BOOT_SUBST_CYCLES == 4'h0) begin : gBadSubst
    $error("boot substitution length must not be zero");
  end
  if (scfg_pkg::STRAP_SETTLE_CYCLES < 2'h2) begin : gBadSettle
    $error("strap settle count must cover both synchroniser flops");
  end

endmodule : scfg_strap_mode

// ************************************************************
// two-flop synchroniser for a pin
// ************************************************************
module scfg_sync2 (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // pin in, synchronised level out
  input  wire logic din,
  output      logic dout
);

  typedef struct packed {
    logic [1:0] stages;
  } scfg_sync_state_t;

  scfg_sync_state_t st;
  scfg_sync_state_t next_st;

  // only the second flop leaves this module; the first may be metastable
  always_comb begin
    next_st        = st;
    next_st.stages = {st.stages[0], din};
    dout           = st.stages[1];
  end

  // resets to the level that the strap pull-ups give
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st.stages <= 2'h3;
    end else begin
      st <= next_st;
    end
  end

endmodule : scfg_sync2

/* test/scfg_strap_board.sv */
/* board model for the strap pins: pulls a strap low on request, else
   releases it; a released pin reads high while the block pulls up, else toggles each clock */
`timescale 1ns/1ps
module scfg_strap_board (
  // control
  input  wire logic       clk,
  input  wire logic       pullUp,
  input  wire logic [1:0] driveLow,
  // straps, bit 0 the low selector
  output      logic [1:0] strapN
);
  logic [1:0] floatVal = 2'h0;
  // an undriven pin has no value; toggling exposes any reliance on it
  always @(posedge clk) floatVal <= ~floatVal;
  always_comb strapN = ~driveLow & (pullUp ? 2'h3 : floatVal);
endmodule : scfg_strap_board

/* test/scfg_strap_mode_monitor.sv */
/* checker for the strap and config block, bound to its top ports;
   assumes one clock domain and the pin gating listed in the block's operation list */
`timescale 1ns/1ps
module scfg_strap_mode_monitor (
  // clock, bus, flash
  input wire logic                     clk,
  input wire logic                     rst,
  input wire scfg_pkg::scfg_apb_req_t  apbReq,
  input wire scfg_pkg::scfg_apb_rsp_t  apbRsp,
  input wire logic                     programFlashBusy,
  input wire logic                     dataFlashBusy,
  // pins and mode
  input wire logic                     strapPullUpEnable,
  input wire logic                     slowPrescalerDividerA,
  input wire scfg_pkg::scfg_env_t      operatingMode,
  input wire logic                     inSystemProgrammingMode,
  input wire logic                     flashFetchDisable,
  input wire logic                     bootBranchSubstitute,
  input wire scfg_pkg::scfg_clk_pins_t clkPins
);
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic stRd = apbReq.psel & apbReq.penable & !apbReq.pwrite
                    & (apbReq.paddr == scfg_pkg::MODULE_STATUS_OFFSET);
  sequence s_subst;
    bootBranchSubstitute [*4] ##1 !bootBranchSubstitute;
  endsequence
  a_pull_sample: assert property ($past(rst, 3) |-> strapPullUpEnable)
    else $error("pull-up off while straps sampled");
  a_pull_off: assert property (!$past(rst, 3) |-> !strapPullUpEnable)
    else $error("pull-up left on after sampling");
  a_mode_hold: assert property (!strapPullUpEnable && !$past(strapPullUpEnable)
    |-> $stable(operatingMode))
    else $error("mode changed without reset");
  a_isp_flag: assert property (inSystemProgrammingMode == (operatingMode == scfg_pkg::SCFG_ENV_ISP))
    else $error("programming flag disagrees with mode");
  a_subst_len: assert property ($rose(bootBranchSubstitute) |-> s_subst)
    else $error("boot substitution length wrong");
  a_subst_fetch: assert property (bootBranchSubstitute |-> flashFetchDisable && inSystemProgrammingMode)
    else $error("substitution without flash disabled");
  a_cfg_clear: assert property ($past(rst) |-> !(clkPins.cpuClockOe | clkPins.genClockAOe))
    else $error("clock output enabled after reset");
  a_cpu_oe_mode: assert property (clkPins.cpuClockOe |-> operatingMode == scfg_pkg::SCFG_ENV_NORMAL)
    else $error("cpu clock driven outside normal mode");
  a_clkb_excl: assert property (clkPins.genClockBOe |-> !clkPins.cpuClockOe)
    else $error("clock b driven with cpu clock on");
  a_pin_gate: assert property (clkPins.genClockAPin == (slowPrescalerDividerA & clkPins.genClockAOe))
    else $error("clock a pin not gated by its enable");
  a_busy_bit: assert property (stRd && apbRsp.pready
    |-> apbRsp.prdata[3] == $past(programFlashBusy | dataFlashBusy, 2))
    else $error("busy status bit wrong");
endmodule : scfg_strap_mode_monitor

/* test/scfg_strap_mode_tb.sv */
/* self-checking bench for the strap and config block; random values from
   seed 54; assumes the board model and checker files are compiled first */
`timescale 1ns/1ps
module scfg_strap_mode_tb;
  logic                     clk = 1'h0, rst = 1'h1, pullUp, in_system_programming_mode, irq, err;
  logic                     empty = 1'h0, pBusy = 1'h0, dBusy = 1'h0;
  logic [1:0]               strapN, lv, driveLow = 2'h0;
  logic [2:0]               srcClk = 3'h0;
  logic [31:0]              rd, wd;
  scfg_pkg::scfg_apb_req_t  apbReq = '0;
  scfg_pkg::scfg_apb_rsp_t  apbRsp;
  scfg_pkg::scfg_env_t      mode;
  scfg_pkg::scfg_clk_pins_t pins;
  int                       seed = 54, errors = 0, totalChecks = 0, cycles = 0;
  always #4 clk = ~clk;
  always @(posedge clk) srcClk <= 3'($random(seed));
  scfg_strap_board board (.clk(clk), .pullUp(pullUp), .driveLow(driveLow), .strapN(strapN));
  scfg_strap_mode dut (.clk(clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
    .strapSelLowN(strapN[0]), .strapSelHighN(strapN[1]), .strapPullUpEnable(pullUp),
    .programMemoryEmptyFlag(empty), .programFlashBusy(pBusy), .dataFlashBusy(dBusy),
    .cpuClock(srcClk[0]), .slowPrescalerDividerA(srcClk[1]), .slowPrescalerDividerB(srcClk[2]),
    .operatingMode(mode), .inSystemProgrammingMode(in_system_programming_mode), .flashFetchDisable(),
    .bootBranchSubstitute(), .clkPins(pins), .irq(irq));
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic finish_test;
    $display("checks %0d errors %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  // one idle cycle before each setup keeps the release and the next request apart
  task automatic apb(input logic wr, input logic [11:0] adr, input logic [31:0] dat);
    @(posedge clk);
    apbReq <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: adr, pwdata: dat};
    @(posedge clk);
    apbReq.penable <= 1'h1;
    // hold until pready at a rising edge; only the bench timeout ends a hang
    do @(posedge clk); while (apbRsp.pready !== 1'h1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
  endtask : apb
  task automatic doReset(input logic [1:0] low, input logic emp);
    driveLow <= low;
    empty <= emp;
    rst <= 1'h1;
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    repeat (4) @(posedge clk);
  endtask : doReset
  function automatic logic [31:0] expMode(input logic [1:0] lvl, input logic emp);
    return (lvl == 2'h3 && emp) ? 32'h2 : 32'(lvl);
  endfunction : expMode
  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    for (int i = 0; i < 5; i++) begin
      lv = (i == 4) ? 2'h3 : 2'(i);
      doReset(~lv, i == 4);
      chk("mode", expMode(lv, i == 4), 32'(mode));
      driveLow <= lv;
      repeat (4) @(posedge clk);
      chk("mode held", expMode(lv, i == 4), 32'(mode));
      apb(1'h0, scfg_pkg::MODULE_STATUS_OFFSET, 32'h0);
      chk("status", 32'(lv), rd);
    end
    doReset(2'h0, 1'h0);
    apb(1'h0, scfg_pkg::MODULE_CONFIGURATION_OFFSET, 32'h0);
    chk("cfg reset", 32'h0, rd);
    for (int i = 0; i < 8; i++) begin
      wd = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h20 : $random(seed);
      apb(1'h1, scfg_pkg::MODULE_CONFIGURATION_OFFSET, wd);
      apb(1'h0, scfg_pkg::MODULE_CONFIGURATION_OFFSET, 32'h0);
      chk("cfg", 32'(wd[7:0] & scfg_pkg::MODULE_CONFIGURATION_WMASK), rd);
      chk("oe", {wd[1], wd[2], wd[5] & !wd[1]}, {pins.cpuClockOe, pins.genClockAOe,
          pins.genClockBOe});
    end
    apb(1'h1, scfg_pkg::MODULE_STATUS_OFFSET, 32'hFFFFFFFF);
    apb(1'h0, scfg_pkg::MODULE_STATUS_OFFSET, 32'h0);
    chk("status ro", 32'h3, rd);
    apb(1'h1, scfg_pkg::EVENT_MASK_OFFSET, 32'h1);
    pBusy <= 1'h1;
    apb(1'h0, scfg_pkg::MODULE_STATUS_OFFSET, 32'h0);
    chk("busy", 32'hB, rd);
    chk("irq on", 32'h1, 32'(irq));
    pBusy <= 1'h0;
    apb(1'h0, scfg_pkg::EVENT_STATUS_OFFSET, 32'h0);
    chk("event both", 32'h3, rd);
    dBusy <= 1'h1;
    apb(1'h0, scfg_pkg::MODULE_STATUS_OFFSET, 32'h0);
    chk("busy data", 32'hB, rd);
    apb(1'h0, scfg_pkg::EVENT_STATUS_OFFSET, 32'h0);
    chk("event rise", 32'h1, rd);
    dBusy <= 1'h0;
    repeat (2) @(posedge clk);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'h0, scfg_pkg::EVENT_STATUS_OFFSET, 32'h0);
    chk("event fall", 32'h2, rd);
    apb(1'h0, 12'h010, 32'h0);
    chk("unmapped", 32'h1, 32'(err));
    finish_test();
  end
endmodule : scfg_strap_mode_tb
bind scfg_strap_mode scfg_strap_mode_monitor mon (.clk(clk), .rst(rst), .apbReq(apbReq),
  .apbRsp(apbRsp), .programFlashBusy(programFlashBusy), .dataFlashBusy(dataFlashBusy),
  .strapPullUpEnable(strapPullUpEnable), .slowPrescalerDividerA(slowPrescalerDividerA),
  .operatingMode(operatingMode), .inSystemProgrammingMode(inSystemProgrammingMode),
  .flashFetchDisable(flashFetchDisable), .bootBranchSubstitute(bootBranchSubstitute),
  .clkPins(clkPins));
